// *** design/vic_top.sv ***
// vic_top: vectored interrupt controller with AXI4-Lite register slave
// assumes event pulses are one cycle in clk domain; pins are asynchronous
`timescale 1ns/1ps

// Operation
// - acknowledge clears global enable
// - blocked requests still latch their flags
// - full stack withholds acknowledge until return
// - only program counter pushed on acknowledge
// - pin edges set flags, edge is option
// - external vectors 04H/08H clear flag, enable; here only the flag is cleared, enable is kept
// - timer A flag bit 6, vector 0CH
// - timer B flag ctrl1 bit 4, vector 10H
// - serial done sets ctrl1 bit 5, 14H
// - serial enable bit 1; software clears flag
// - multi sources set ctrl1 bit 6, 18H
// - multi source status bits software cleared
// - interrupt return sets enable, subroutine not
// - nesting needs global and source enable
// - service at next phase two strobe
// - fixed priority external A first
// - global enable off masks all
// - any request wakes halted core
// - control 0 bit layout active high
// - flags hold until serviced or cleared
module vic_top #(
   parameter vic_pkg::vic_edge_t EXT_EDGE = vic_pkg::VIC_EDGE_FALL
) (
   input  wire logic                 clk,
   input  wire logic                 rstn,
   input  wire logic [9:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [9:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic                 extIrqPinA,
   input  wire logic                 extIrqPinB,
   input  wire vic_pkg::vic_events_t events,
   input  wire vic_pkg::vic_core_t   core,
   output logic                      irqAck,
   output logic [12:0]               irqVector,
   output logic                      pushPc,
   output logic                      wakeUp
);

   // pin synchronisers: first stage read only by second
   logic [1:0] pinS1_q, pinS2_q, pinS3_q;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pinS1_q <= 2'b11;
         pinS2_q <= 2'b11;
         pinS3_q <= 2'b11;
      end else begin
         pinS1_q <= {extIrqPinB, extIrqPinA};
         pinS2_q <= pinS1_q;
         pinS3_q <= pinS2_q;
      end
   end

   // edge detection per build option
   logic [1:0] pinEdge;
   always_comb begin
      case (EXT_EDGE)
         vic_pkg::VIC_EDGE_RISE: pinEdge = pinS2_q & ~pinS3_q;
         vic_pkg::VIC_EDGE_BOTH: pinEdge = pinS2_q ^ pinS3_q;
         default:                pinEdge = ~pinS2_q & pinS3_q;
      endcase
   end

   // register state
   logic [7:0] ctrl0_q, ctrl0_d;
   logic [7:0] ctrl1_q, ctrl1_d;
   logic [3:0] mfStat_q, mfStat_d;
   vic_pkg::vic_state_t st_q, st_d;
   logic        ack_q, ack_d;
   logic [12:0] vec_q, vec_d;
   logic        wake_q, wake_d;

   // bus channel state
   logic        awHeld_q, awHeld_d, wHeld_q, wHeld_d;
   logic [9:0]  awAddr_q, awAddr_d;
   logic [31:0] wData_q, wData_d;
   logic [3:0]  wStrb_q, wStrb_d;
   logic        bValid_q, bValid_d, rValid_q, rValid_d;
   logic [1:0]  bResp_q, bResp_d, rResp_q, rResp_d;
   logic [31:0] rData_q, rData_d;
   logic        awRdy_q, awRdy_d, wRdy_q, wRdy_d, arRdy_q, arRdy_d;

   // pending and priority
   logic [5:0] pend;
   logic       stackFull;
   logic       doWrite;
   always_comb begin
      stackFull = (core.stackLevel >= 5'(vic_pkg::STACK_DEPTH));
      // source enable gates each flag; global enable is checked at service
      pend[0] = ctrl0_q[vic_pkg::C0_EA_EN] & ctrl0_q[vic_pkg::C0_EA_F];
      pend[1] = ctrl0_q[vic_pkg::C0_EB_EN] & ctrl0_q[vic_pkg::C0_EB_F];
      pend[2] = ctrl0_q[vic_pkg::C0_TA_EN] & ctrl0_q[vic_pkg::C0_TA_F];
      pend[3] = ctrl1_q[vic_pkg::C1_TB_EN] & ctrl1_q[vic_pkg::C1_TB_F];
      pend[4] = ctrl1_q[vic_pkg::C1_SR_EN] & ctrl1_q[vic_pkg::C1_SR_F];
      pend[5] = ctrl1_q[vic_pkg::C1_MF_EN] & ctrl1_q[vic_pkg::C1_MF_F];
      doWrite = awHeld_q & wHeld_q & ~bValid_q;
   end

   // flags, enables, acknowledge sequencing
   always_comb begin
      ctrl0_d  = ctrl0_q;
      ctrl1_d  = ctrl1_q;
      mfStat_d = mfStat_q;
      st_d     = st_q;
      ack_d    = 1'b0;
      vec_d    = vec_q;
      // software write first so hardware set wins afterwards
      if (doWrite && wStrb_q[0]) begin
         if (awAddr_q == vic_pkg::ADDR_CTRL0) begin
            ctrl0_d = wData_q[7:0];
         end else if (awAddr_q == vic_pkg::ADDR_CTRL1) begin
            ctrl1_d = wData_q[7:0] & vic_pkg::MASK_CTRL1;
         end else if (awAddr_q == vic_pkg::ADDR_MFSTAT) begin
            mfStat_d = wData_q[3:0];
         end
      end
      if (core.retInt) begin
         ctrl0_d[vic_pkg::C0_GIE] = 1'b1;
      end
      // service on phase two strobe, highest first, rest stay
      case (st_q)
         vic_pkg::VIC_ST_IDLE: begin
            if (core.phaseTwo && ctrl0_q[vic_pkg::C0_GIE] && !stackFull
                && (pend != 6'h00)) begin
               ack_d = 1'b1;
               st_d  = vic_pkg::VIC_ST_ACK;
               ctrl0_d[vic_pkg::C0_GIE] = 1'b0;
               if (pend[0]) begin
                  vec_d = vic_pkg::VEC_EXT_A;
                  ctrl0_d[vic_pkg::C0_EA_F] = 1'b0;
               end else if (pend[1]) begin
                  vec_d = vic_pkg::VEC_EXT_B;
                  ctrl0_d[vic_pkg::C0_EB_F] = 1'b0;
               end else if (pend[2]) begin
                  vec_d = vic_pkg::VEC_TIMER_A;
                  ctrl0_d[vic_pkg::C0_TA_F] = 1'b0;
               end else if (pend[3]) begin
                  vec_d = vic_pkg::VEC_TIMER_B;
                  ctrl1_d[vic_pkg::C1_TB_F] = 1'b0;
               end else if (pend[4]) begin
                  vec_d = vic_pkg::VEC_SERIAL;
               end else begin
                  vec_d = vic_pkg::VEC_MULTI;
                  ctrl1_d[vic_pkg::C1_MF_F] = 1'b0;
               end
            end
         end
         default: begin
            st_d = vic_pkg::VIC_ST_IDLE;
         end
      endcase
      // hardware sets win over any clear
      if (pinEdge[0])       ctrl0_d[vic_pkg::C0_EA_F] = 1'b1;
      if (pinEdge[1])       ctrl0_d[vic_pkg::C0_EB_F] = 1'b1;
      if (events.timerA)    ctrl0_d[vic_pkg::C0_TA_F] = 1'b1;
      if (events.timerB)    ctrl1_d[vic_pkg::C1_TB_F] = 1'b1;
      if (events.serial)    ctrl1_d[vic_pkg::C1_SR_F] = 1'b1;
      if (events.remoteOvf) mfStat_d[vic_pkg::MS_OVF]  = 1'b1;
      if (events.tick)      mfStat_d[vic_pkg::MS_TICK] = 1'b1;
      if (events.remoteRise) mfStat_d[vic_pkg::MS_RISE] = 1'b1;
      if (events.remoteFall) mfStat_d[vic_pkg::MS_FALL] = 1'b1;
      if (events.remoteOvf | events.tick | events.remoteRise | events.remoteFall) begin
         ctrl1_d[vic_pkg::C1_MF_F] = 1'b1;
      end
      // any latched request wakes a halted core
      wake_d = core.halted && ((ctrl0_d[6:4] != 3'h0) || (ctrl1_d[6:4] != 3'h0));
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrl0_q  <= vic_pkg::RST_CTRL0;
         ctrl1_q  <= vic_pkg::RST_CTRL1;
         mfStat_q <= vic_pkg::RST_MFSTAT;
         st_q     <= vic_pkg::VIC_ST_IDLE;
         ack_q    <= 1'b0;
         vec_q    <= 13'h0000;
         wake_q   <= 1'b0;
      end else begin
         ctrl0_q  <= ctrl0_d;
         ctrl1_q  <= ctrl1_d;
         mfStat_q <= mfStat_d;
         st_q     <= st_d;
         ack_q    <= ack_d;
         vec_q    <= vec_d;
         wake_q   <= wake_d;
      end
   end

   // ack doubles as pc push; no other state is saved
   assign irqAck    = ack_q;
   assign pushPc    = ack_q;
   assign irqVector = vec_q;
   assign wakeUp    = wake_q;

   // axi-lite slave: one write and one read at a time
   always_comb begin
      awHeld_d = awHeld_q;
      wHeld_d  = wHeld_q;
      awAddr_d = awAddr_q;
      wData_d  = wData_q;
      wStrb_d  = wStrb_q;
      bValid_d = bValid_q;
      bResp_d  = bResp_q;
      rValid_d = rValid_q;
      rResp_d  = rResp_q;
      rData_d  = rData_q;
      if (s_axi_awvalid && !awHeld_q) begin
         awHeld_d = 1'b1;
         awAddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_q) begin
         wHeld_d = 1'b1;
         wData_d = s_axi_wdata;
         wStrb_d = s_axi_wstrb;
      end
      if (doWrite) begin
         bValid_d = 1'b1;
         awHeld_d = 1'b0;
         wHeld_d  = 1'b0;
         if (awAddr_q == vic_pkg::ADDR_CTRL0 || awAddr_q == vic_pkg::ADDR_CTRL1
             || awAddr_q == vic_pkg::ADDR_MFSTAT) begin
            bResp_d = 2'b00;
         end else begin
            bResp_d = 2'b10; // unmapped or read-only
         end
      end else if (bValid_q && s_axi_bready) begin
         bValid_d = 1'b0;
      end
      if (s_axi_arvalid && !rValid_q) begin
         rValid_d = 1'b1;
         rResp_d  = 2'b00;
         if (s_axi_araddr == vic_pkg::ADDR_CTRL0) begin
            rData_d = {24'h000000, ctrl0_q};
         end else if (s_axi_araddr == vic_pkg::ADDR_CTRL1) begin
            rData_d = {24'h000000, ctrl1_q};
         end else if (s_axi_araddr == vic_pkg::ADDR_MFSTAT) begin
            rData_d = {28'h0000000, mfStat_q}; // no clear on read
         end else if (s_axi_araddr == vic_pkg::ADDR_CORESTAT) begin
            rData_d = {26'h0000000, stackFull, core.stackLevel};
         end else begin
            rData_d = 32'h00000000;
            rResp_d = 2'b10;
         end
      end else if (rValid_q && s_axi_rready) begin
         rValid_d = 1'b0;
      end
      // readies follow the next held state
      awRdy_d = ~awHeld_d;
      wRdy_d  = ~wHeld_d;
      arRdy_d = ~rValid_d;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         awAddr_q <= 10'h000;
         wData_q  <= 32'h00000000;
         wStrb_q  <= 4'h0;
         bValid_q <= 1'b0;
         bResp_q  <= 2'b00;
         rValid_q <= 1'b0;
         rResp_q  <= 2'b00;
         rData_q  <= 32'h00000000;
         awRdy_q  <= 1'b1;
         wRdy_q   <= 1'b1;
         arRdy_q  <= 1'b1;
      end else begin
         awHeld_q <= awHeld_d;
         wHeld_q  <= wHeld_d;
         awAddr_q <= awAddr_d;
         wData_q  <= wData_d;
         wStrb_q  <= wStrb_d;
         bValid_q <= bValid_d;
         bResp_q  <= bResp_d;
         rValid_q <= rValid_d;
         rResp_q  <= rResp_d;
         rData_q  <= rData_d;
         awRdy_q  <= awRdy_d;
         wRdy_q   <= wRdy_d;
         arRdy_q  <= arRdy_d;
      end
   end

   // ready is registered-state based so outputs stem from flops
   assign s_axi_awready = awRdy_q;
   assign s_axi_wready  = wRdy_q;
   assign s_axi_bvalid  = bValid_q;
   assign s_axi_bresp   = bResp_q;
   assign s_axi_arready = arRdy_q;
   assign s_axi_rvalid  = rValid_q;
   assign s_axi_rresp   = rResp_q;
   assign s_axi_rdata   = rData_q;

   // assertions
   sequence s_ackTaken;
      ack_q;
   endsequence

   a_ack_clears_gie: assert property (@(posedge clk) disable iff (!rstn)
      s_ackTaken |-> !ctrl0_q[vic_pkg::C0_GIE] || $past(core.retInt))
      else $error("global enable still set after acknowledge");
   a_full_blocks_ack: assert property (@(posedge clk) disable iff (!rstn)
      $past(stackFull) |-> !ack_q)
      else $error("acknowledge with full stack");
   a_gie_masks_all: assert property (@(posedge clk) disable iff (!rstn)
      !$past(ctrl0_q[vic_pkg::C0_GIE]) |-> !ack_q)
      else $error("acknowledge while globally masked");
   a_phase_two_only: assert property (@(posedge clk) disable iff (!rstn)
      ack_q |-> $past(core.phaseTwo))
      else $error("acknowledge off phase two strobe");
   a_ext_a_first: assert property (@(posedge clk) disable iff (!rstn)
      ack_q && $past(pend[0]) |-> irqVector == vic_pkg::VEC_EXT_A)
      else $error("priority violated for pin a");
   a_multi_vector: assert property (@(posedge clk) disable iff (!rstn)
      ack_q && $past(pend) == 6'h20 |-> irqVector == vic_pkg::VEC_MULTI)
      else $error("multi source vector wrong");
   a_return_from_interrupt_sets_gie: assert property (@(posedge clk) disable iff (!rstn)
      core.retInt |=> ctrl0_q[vic_pkg::C0_GIE])
      else $error("interrupt return did not set enable");
   a_event_sets_flag: assert property (@(posedge clk) disable iff (!rstn)
      events.timerA |=> ctrl0_q[vic_pkg::C0_TA_F])
      else $error("timer a flag missed");
   a_serial_kept: assert property (@(posedge clk) disable iff (!rstn)
      ack_q && irqVector == vic_pkg::VEC_SERIAL |-> ctrl1_q[vic_pkg::C1_SR_F])
      else $error("serial flag cleared by vectoring");
   a_ack_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
      ack_q |=> !ack_q)
      else $error("acknowledge longer than one cycle");

   // flag holding, wake and plain return
   a_plain_ret_keeps: assert property (@(posedge clk) disable iff (!rstn)
      core.retSub && !core.retInt && !doWrite && !ack_d |=>
      ctrl0_q[vic_pkg::C0_GIE] == $past(ctrl0_q[vic_pkg::C0_GIE]))
      else $error("subroutine return changed global enable");
   a_flag_holds: assert property (@(posedge clk) disable iff (!rstn)
      ctrl0_q[vic_pkg::C0_TA_F] && !doWrite && !ack_d |=> ctrl0_q[vic_pkg::C0_TA_F])
      else $error("timer a flag dropped unserviced");
   a_blocked_latch: assert property (@(posedge clk) disable iff (!rstn)
      !ctrl0_q[vic_pkg::C0_GIE] && events.serial |=> ctrl1_q[vic_pkg::C1_SR_F])
      else $error("blocked serial request not latched");
   a_serial_wakes: assert property (@(posedge clk) disable iff (!rstn)
      core.halted && events.serial |=> wakeUp)
      else $error("halted core not woken");
   a_pin_sets_flag: assert property (@(posedge clk) disable iff (!rstn)
      pinEdge[0] |=> ctrl0_q[vic_pkg::C0_EA_F])
      else $error("pin a edge not latched");
   a_ext_clears_flag: assert property (@(posedge clk) disable iff (!rstn)
      ack_q && irqVector == vic_pkg::VEC_EXT_A |->
      !ctrl0_q[vic_pkg::C0_EA_F] || $past(pinEdge[0]))
      else $error("pin a flag kept after vectoring");
   a_timer_b_vector: assert property (@(posedge clk) disable iff (!rstn)
      ack_q && $past(pend) == 6'h08 |-> irqVector == vic_pkg::VEC_TIMER_B)
      else $error("timer b vector wrong");

endmodule

// *** design/vic_pkg.sv ***
// vic_pkg: constants and carrier types for the vectored interrupt controller
// assumes a 32-bit AXI4-Lite register bus and an 8-bit core with a 16-level return stack
package vic_pkg;

   // register byte addresses (printed offsets 0x0b and 0x1e are not word aligned)
   localparam logic [7:0] IDX_CTRL0     = 8'h0b;
   localparam logic [7:0] IDX_CTRL1     = 8'h1e;
   localparam logic [7:0] IDX_MFSTAT    = 8'h29;
   localparam logic [7:0] IDX_CORESTAT  = 8'h30;
   localparam logic [9:0] ADDR_CTRL0    = {IDX_CTRL0, 2'b00};
   localparam logic [9:0] ADDR_CTRL1    = {IDX_CTRL1, 2'b00};
   localparam logic [9:0] ADDR_MFSTAT   = {IDX_MFSTAT, 2'b00};
   localparam logic [9:0] ADDR_CORESTAT = {IDX_CORESTAT, 2'b00};

   // control 0 fields
   localparam int C0_GIE   = 0;
   localparam int C0_EA_EN = 1;
   localparam int C0_EB_EN = 2;
   localparam int C0_TA_EN = 3;
   localparam int C0_EA_F  = 4;
   localparam int C0_EB_F  = 5;
   localparam int C0_TA_F  = 6;
   localparam int C0_TEST  = 7;
   // control 1 fields
   localparam int C1_TB_EN = 0;
   localparam int C1_SR_EN = 1;
   localparam int C1_MF_EN = 2;
   localparam int C1_TB_F  = 4;
   localparam int C1_SR_F  = 5;
   localparam int C1_MF_F  = 6;
   // multi-source status fields
   localparam int MS_OVF  = 0;
   localparam int MS_TICK = 1;
   localparam int MS_RISE = 2;
   localparam int MS_FALL = 3;

   localparam logic [7:0] RST_CTRL0  = 8'h00;
   localparam logic [7:0] RST_CTRL1  = 8'h00;
   localparam logic [3:0] RST_MFSTAT = 4'h0;
   localparam logic [7:0] MASK_CTRL1 = 8'h77;

   // fixed vectors, highest priority first
   localparam logic [12:0] VEC_EXT_A   = 13'h0004;
   localparam logic [12:0] VEC_EXT_B   = 13'h0008;
   localparam logic [12:0] VEC_TIMER_A = 13'h000c;
   localparam logic [12:0] VEC_TIMER_B = 13'h0010;
   localparam logic [12:0] VEC_SERIAL  = 13'h0014;
   localparam logic [12:0] VEC_MULTI   = 13'h0018;

   localparam int STACK_DEPTH = 16;

   // external pin edge option
   typedef enum logic [1:0] {
      VIC_EDGE_FALL = 2'b00,
      VIC_EDGE_RISE = 2'b01,
      VIC_EDGE_BOTH = 2'b10
   } vic_edge_t;

   // core sequencer handshake
   typedef enum logic [1:0] {
      VIC_ST_IDLE = 2'b00,
      VIC_ST_ACK  = 2'b01
   } vic_state_t;

   // event pulses from peripherals
   typedef struct packed {
      logic timerA;
      logic timerB;
      logic serial;
      logic tick;
      logic remoteRise;
      logic remoteFall;
      logic remoteOvf;
   } vic_events_t;

   // core status toward the controller
   typedef struct packed {
      logic       phaseTwo;   // phase two clock strobe
      logic       retInt;     // return_from_interrupt executed
      logic       retSub;     // subroutine_return executed
      logic       halted;
      logic [4:0] stackLevel; // entries in use
   } vic_core_t;

endpackage

// *** tb/vic_core_model.sv ***
// vic_core_model: core sequencer stand-in: strobes, returns, halt, stack level
// assumes pushPc is a one-cycle pulse from the controller
`timescale 1ns/1ps
module vic_core_model (
   input  wire logic          clk,
   input  wire logic          rstn,
   input  wire logic          pushPc,
   input  wire logic          doRetInt,
   input  wire logic          doRetSub,
   input  wire logic          fillStack,
   input  wire logic          slowPhase,
   input  wire logic          halt,
   output vic_pkg::vic_core_t core
);
   logic [1:0] phaseCnt;

   // only the return address is stacked, status saving is the handler's job
   always_ff @(posedge clk) begin
      if (!rstn) begin
         core     <= '0;
         phaseCnt <= 2'h0;
      end else begin
         phaseCnt      <= phaseCnt + 2'h1;
         core.phaseTwo <= slowPhase ? (phaseCnt == 2'h3) : 1'h1; // slow: one strobe in four
         core.retInt   <= doRetInt;
         core.retSub   <= doRetSub;
         core.halted   <= halt;
         if (fillStack) begin
            core.stackLevel <= 5'h10;
         end else if (pushPc && core.stackLevel != 5'h10) begin
            core.stackLevel <= core.stackLevel + 5'h1; // a push when full is ignored, level stays at 16
         end else if ((doRetInt || doRetSub) && core.stackLevel != 5'h0) begin
            core.stackLevel <= core.stackLevel - 5'h1;
         end
      end
   end
endmodule

// *** tb/tb.sv ***
// tb: self-checking bench for vic_top with a core model on the far side
// assumes package addresses; default falling-edge pin build
`timescale 1ns/1ps
module tb;
   logic                 clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic                 s_axi_rready, pinA, pinB, return_from_interrupt, retS, fill, slow, halt;
   logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic                 irqAck, pushPc, wakeUp;
   logic [9:0]           s_axi_awaddr, s_axi_araddr;
   logic [31:0]          s_axi_wdata, s_axi_rdata, seed;
   logic [3:0]           s_axi_wstrb;
   logic [1:0]           s_axi_bresp, s_axi_rresp, rsp;
   logic [12:0]          irqVector, lastVec;
   logic [7:0]           rdv;
   vic_pkg::vic_events_t events;
   vic_pkg::vic_core_t   core;
   int                   errCount, nCompared, ackCnt, s;

   vic_top u_dut (
      .clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .extIrqPinA(pinA), .extIrqPinB(pinB), .events(events), .core(core), .irqAck(irqAck),
      .irqVector(irqVector), .pushPc(pushPc), .wakeUp(wakeUp));

   vic_core_model u_core (
      .clk(clk), .rstn(rstn), .pushPc(pushPc), .doRetInt(return_from_interrupt), .doRetSub(retS),
      .fillStack(fill), .slowPhase(slow), .halt(halt), .core(core));

   always #12.5 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      nCompared++;
      if (got !== exp) begin
         errCount++;
         $display("[FAIL] %0t %s: got %0h expected %0h", $time, m, got, exp);
      end
   endtask

   task automatic completeRun();
      $display("compared %0d, mismatches %0d", nCompared, errCount);
      if (errCount == 0 && nCompared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic done(input string n);
      $display("test %s finished, %0d mismatches so far", n, errCount);
   endtask

   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata   <= {24'h0, d};
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask

   task automatic rd(input logic [9:0] a);
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      rdv = s_axi_rdata[7:0];
      rsp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask

   task automatic rdc(input logic [9:0] a, input logic [7:0] e, input string m);
      rd(a);
      chk(rdv, e, m);
   endtask

   task automatic pulse(input logic [6:0] ev);
      @(posedge clk);
      events <= ev;
      @(posedge clk);
      events <= '0;
   endtask

   task automatic ret(input logic isInt);
      @(posedge clk);
      return_from_interrupt <= isInt;
      retS <= !isInt;
      @(posedge clk);
      return_from_interrupt <= 1'h0;
      retS <= 1'h0;
   endtask

   // bounded wait for the next acknowledge, then check its vector
   task automatic waitAck(input logic [12:0] v);
      int n, s0;
      s0 = ackCnt;
      for (n = 0; n < 100 && ackCnt == s0; n++) @(posedge clk);
      chk(ackCnt - s0, 1, "one ack");
      chk(lastVec, v, "vector");
   endtask

   // vectors step by four from 04h in priority order
   function automatic logic [12:0] vecOf(input int k);
      return 13'(4 * (k + 1));
   endfunction

   // expected {status, ctrl1 flags, ctrl0 flags} after one burst of events
   function automatic logic [23:0] flagsOf(input vic_pkg::vic_events_t e);
      logic mf;
      mf = e.tick | e.remoteRise | e.remoteFall | e.remoteOvf;
      return {4'h0, e.remoteFall, e.remoteRise, e.tick, e.remoteOvf,
              1'h0, mf, e.serial, e.timerB, 4'h0, 1'h0, e.timerA, 6'h0};
   endfunction

   function automatic logic [31:0] nxt(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // ack monitor: vector latched, every ack must push
   always @(posedge clk) begin
      if (irqAck === 1'h1) begin
         ackCnt  <= ackCnt + 1;
         lastVec <= irqVector;
         chk(pushPc, 1, "push with ack");
      end
   end

   // watchdog sized well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      errCount++;
      $display("[FAIL] %0t watchdog expired", $time);
      completeRun();
   end

   initial begin
      logic [23:0] acc;
      clk = 1'h0;
      rstn = 1'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {return_from_interrupt, retS, fill, slow, halt} = '0;
      {pinA, pinB} = 2'h3;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, events, lastVec} = '0;
      s_axi_wstrb = 4'hf;
      {errCount, nCompared, ackCnt} = '0;
      seed = 32'd54;
      repeat (10) @(posedge clk);
      rstn <= 1'h1;
      rdc(vic_pkg::ADDR_CTRL0, 8'h00, "ctrl0 reset");
      rdc(vic_pkg::ADDR_CTRL1, 8'h00, "ctrl1 reset");
      rdc(vic_pkg::ADDR_MFSTAT, 8'h00, "status reset");
      rd(10'h100);
      chk(rsp, 2'h2, "unmapped read");
      wr(10'h100, 8'hff);
      chk(rsp, 2'h2, "unmapped write");
      repeat (6) begin
         seed = nxt(seed);
         wr(vic_pkg::ADDR_CTRL0, seed[7:0] & 8'h8e);
         rdc(vic_pkg::ADDR_CTRL0, seed[7:0] & 8'h8e, "ctrl0 rw");
      end
      done("registers");
      // enables on but global off: bursts latch, never vector
      wr(vic_pkg::ADDR_CTRL0, 8'h0e);
      wr(vic_pkg::ADDR_CTRL1, 8'h07);
      halt <= 1'h1;
      acc = '0;
      s = ackCnt;
      repeat (8) begin
         seed = nxt(seed);
         pulse(seed[6:0]);
         acc = acc | flagsOf(seed[6:0]);
      end
      repeat (4) @(posedge clk);
      chk(ackCnt, s, "blocked ack");
      rdc(vic_pkg::ADDR_CTRL0, 8'h0e | acc[7:0], "ctrl0 flags");
      rdc(vic_pkg::ADDR_CTRL1, 8'h07 | acc[15:8], "ctrl1 flags");
      rdc(vic_pkg::ADDR_MFSTAT, acc[23:16], "status flags");
      chk(wakeUp, acc != 0, "wake");
      wr(vic_pkg::ADDR_CTRL0, 8'h0e);
      wr(vic_pkg::ADDR_CTRL1, 8'h07);
      wr(vic_pkg::ADDR_MFSTAT, 8'h00);
      repeat (3) @(posedge clk);
      chk(wakeUp, 0, "asleep");
      done("blocked");
      // every source at once, drained one per interrupt return, slow strobe
      slow <= 1'h1;
      pinA <= 1'h0;
      pinB <= 1'h0;
      pulse(7'h7f);
      repeat (4) @(posedge clk);
      rdc(vic_pkg::ADDR_CTRL0, 8'h7e, "pin flags");
      s = ackCnt;
      wr(vic_pkg::ADDR_CTRL0, 8'h7f);
      for (int k = 0; k < 6; k++) begin
         waitAck(vecOf(k));
         rd(vic_pkg::ADDR_CTRL0);
         chk(rdv & (k == 0 ? 8'hff : 8'h01), k == 0 ? 8'h6e : 8'h00, "after ack");
         if (k == 0) begin
            ret(1'h0);
            repeat (8) @(posedge clk);
            chk(ackCnt, s + 1, "plain return");
         end
         if (k == 4) begin
            rdc(vic_pkg::ADDR_CTRL1, 8'h67, "serial kept");
            wr(vic_pkg::ADDR_CTRL1, 8'h47);
         end
         ret(1'h1);
      end
      rdc(vic_pkg::ADDR_CTRL1, 8'h07, "multi reset");
      rdc(vic_pkg::ADDR_MFSTAT, 8'h0f, "status kept");
      wr(vic_pkg::ADDR_MFSTAT, 8'h00);
      done("priority");
      // full stack withholds until a return pops it
      slow <= 1'h0;
      fill <= 1'h1;
      @(posedge clk);
      fill <= 1'h0;
      s = ackCnt;
      pulse(7'h40);
      repeat (20) @(posedge clk);
      chk(ackCnt, s, "full stack");
      rdc(vic_pkg::ADDR_CORESTAT, 8'h30, "stack full status");
      rdc(vic_pkg::ADDR_CTRL0, 8'h4f, "flag pending");
      ret(1'h0);
      waitAck(vecOf(2));
      rdc(vic_pkg::ADDR_CTRL0, 8'h0e, "timer flag reset");
      ret(1'h0);
      pulse(7'h20);
      repeat (10) @(posedge clk);
      chk(ackCnt, s + 1, "held in handler");
      wr(vic_pkg::ADDR_CTRL0, 8'h0f);
      waitAck(vecOf(3));
      ret(1'h1);
      done("stack and nesting");
      // rising pin edges ignored by the falling-edge build
      wr(vic_pkg::ADDR_CTRL0, 8'h00);
      pinA <= 1'h1;
      pinB <= 1'h1;
      repeat (6) @(posedge clk);
      rdc(vic_pkg::ADDR_CTRL0, 8'h00, "rising ignored");
      done("pins");
      completeRun();
   end
endmodule
